// [pdo_pkg.sv]
// shared constants and types for the decoder serial output port
package pdo_pkg;

  //----------------------------------------------------------------
  // word layout
  //----------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam int LEN_W = 4;
  localparam int ENTRY_W = LEN_W + WORD_W;
  localparam int FIFO_DEPTH = 16;

  //----------------------------------------------------------------
  // rate selection by falling edges seen while the input strobe is high
  //----------------------------------------------------------------
  localparam logic [LEN_W-1:0] EDGES_SHORT = 4'h1;
  localparam logic [LEN_W-1:0] EDGES_16K = 4'h2;
  localparam logic [LEN_W-1:0] EDGES_24K = 4'h3;
  localparam logic [LEN_W-1:0] EDGES_32K = 4'h4;
  localparam logic [LEN_W-1:0] EDGES_64K_MAX = 4'h8;

  //----------------------------------------------------------------
  // output word lengths in bits, and the request edge count that selects long reads
  //----------------------------------------------------------------
  localparam logic [LEN_W-1:0] LEN_16K = 4'h2;
  localparam logic [LEN_W-1:0] LEN_24K = 4'h3;
  localparam logic [LEN_W-1:0] LEN_32K = 4'h4;
  localparam logic [LEN_W-1:0] LEN_64K = 4'h8;
  localparam logic [LEN_W-1:0] LONG_OUT_LEN = 4'h8;
  localparam logic [1:0] LONG_OUT_EDGES = 2'h2;

  //----------------------------------------------------------------
  // reset values
  //----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [LEN_W-1:0] LEN_RST = 4'h0;

  //----------------------------------------------------------------
  // state types
  //----------------------------------------------------------------
  typedef enum logic [1:0] {CAP_IDLE, CAP_LONG, CAP_SHORT} pdo_cap_e;
  typedef enum logic {OUT_IDLE, OUT_SEND} pdo_out_e;

endpackage

// [pdo_fifo_if.sv]
// valid/ready carrier between the core pipeline and the word fifo
`timescale 1ns/10ps
`default_nettype none

interface pdo_fifo_if #(
  parameter int WIDTH = 8
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );
  modport user (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data
  );
endinterface

`default_nettype wire

// [pdo_fifo.sv]
// synchronous word fifo with registered read data
`timescale 1ns/10ps
`default_nettype none

module pdo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // core clock
  input wire logic i_reset, // async reset, high
  pdo_fifo_if.fifo io // push and pop sides
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] out;
    logic out_v;
  } pdo_fifo_s;

  pdo_fifo_s q;
  pdo_fifo_s d;
  logic push;
  logic pop;

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  // refill the output register whenever it empties or is taken
  always_comb begin
    d = q;
    push = io.wr_valid && (q.cnt != FULL_CNT);
    pop = 1'b0;
    if (io.rd_ready && q.out_v) begin
      d.out_v = 1'b0;
    end
    if ((q.cnt != '0) && (!q.out_v || io.rd_ready)) begin
      pop = 1'b1;
      d.out = q.mem[q.rp];
      d.out_v = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    if (push) begin
      d.mem[q.wp] = io.wr_data;
      d.wp = q.wp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  //----------------------------------------------------------------
  // state register
  //----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // flags straight from state
  assign io.wr_ready = (q.cnt != FULL_CNT);
  assign io.rd_valid = q.out_v;
  assign io.rd_data = q.out;

endmodule

`default_nettype wire

// [pdo_serial_out.sv]
// decoder serial output port: capture, frame pipeline, fifo and shifter
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------
// Overview of operation
// - each short-request frame shifts out the bit count of the input rate two frames earlier
// - words pass capture, decode and read-out in three successive frames
// - long frame request over two falling edges yields at least eight bits
// - request held past the half-period last bit stretches it to a period
// - request still high after the word recirculates the same eight bits
// - output stays high impedance except while presenting requested bits
// - bits launch on rising bit clock edges, input sampled on falling
// - 4 edges 32k, 3 edges 24k, 2 edges 16k, 5 to 8 edges 64k
//----------------------------------------------------------------

module pdo_serial_out
  import pdo_pkg::*;
#(
  parameter int DEPTH_P = FIFO_DEPTH
) (
  input wire logic i_clk, // core clock, 25 MHz
  input wire logic i_reset, // async reset, high
  input wire logic i_decoder_bit_clock, // link bit clock
  input wire logic i_decoder_input_strobe, // input frame strobe
  input wire logic i_decoder_serial_in, // serial word in
  input wire logic i_decoder_output_request, // output request strobe
  output logic o_decoder_serial_out, // serial word out
  output logic o_decoder_serial_out_oe_n, // low while driving
  output logic o_overrun // pulse: captured word lost
);

  //----------------------------------------------------------------
  // state types
  //----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cap_sync;
    logic cap_seen;
    logic [1:0] ack_sync;
    logic pend_v;
    logic [ENTRY_W-1:0] pend;
    logic dec_v;
    logic [ENTRY_W-1:0] dec;
    logic [ENTRY_W-1:0] xfer;
    logic xfer_tgl;
    logic drop;
  } pdo_core_s;

  typedef struct packed {
    pdo_cap_e st;
    logic [LEN_W-1:0] cnt;
    logic [WORD_W-1:0] sh;
    logic [WORD_W-1:0] cap_word;
    logic [LEN_W-1:0] cap_len;
    logic cap_tgl;
    logic [1:0] long_cnt;
    logic cut;
  } pdo_fall_s;

  typedef struct packed {
    logic [1:0] req_sync;
    logic ack_tgl;
    logic hold_v;
    logic [ENTRY_W-1:0] hold;
    pdo_out_e st;
    logic [WORD_W-1:0] sh;
    logic [WORD_W-1:0] word;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] idx;
    logic req_prev;
    logic act;
    logic dout;
  } pdo_rise_s;

  pdo_core_s cq;
  pdo_core_s cd;
  pdo_fall_s fq;
  pdo_fall_s fd;
  pdo_rise_s rq;
  pdo_rise_s rd;
  logic wr_v;
  logic rd_r;
  logic is_long;
  logic [LEN_W-1:0] total;
  logic last_bit;

  pdo_fifo_if #(.WIDTH(ENTRY_W)) fifo_bus ();

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  // word length from strobe edge count
  function automatic logic [LEN_W-1:0] len_of(input logic [LEN_W-1:0] edges);
    logic [LEN_W-1:0] n;
    unique case (edges)
      EDGES_16K: n = LEN_16K;
      EDGES_24K: n = LEN_24K;
      EDGES_32K: n = LEN_32K;
      default: n = LEN_64K;
    endcase
    return n;
  endfunction

  // move the word to the top so it leaves msb first
  function automatic logic [ENTRY_W-1:0] justify(input logic [ENTRY_W-1:0] e);
    logic [WORD_W-1:0] w;
    w = e[WORD_W-1:0] << (LEN_64K - e[ENTRY_W-1:WORD_W]);
    return {e[ENTRY_W-1:WORD_W], w};
  endfunction

  // shared view of the output sequence, same clock both edges
  // long mode is latched on falls, so the length switches to eight mid-word
  assign is_long = (fq.long_cnt == LONG_OUT_EDGES);
  assign total = is_long ? LONG_OUT_LEN : rq.len;
  assign last_bit = rq.act && ((rq.idx + 4'h1) == total);

  //----------------------------------------------------------------
  // link falling edge: input capture and output request watch
  //----------------------------------------------------------------
  // count strobe edges, collect bits, publish word with a toggle
  always_comb begin
    fd = fq;
    unique case (fq.st)
      CAP_IDLE: begin
        if (i_decoder_input_strobe) begin
          fd.cnt = 4'h1;
          fd.sh = {fq.sh[WORD_W-2:0], i_decoder_serial_in};
          fd.st = CAP_LONG;
        end
      end
      CAP_LONG: begin
        if (i_decoder_input_strobe) begin
          if (fq.cnt != EDGES_64K_MAX) begin
            fd.cnt = fq.cnt + 4'h1;
          end
          fd.sh = {fq.sh[WORD_W-2:0], i_decoder_serial_in};
        end else if (fq.cnt == EDGES_SHORT) begin
          fd.cnt = 4'h1;
          fd.sh = {fq.sh[WORD_W-2:0], i_decoder_serial_in};
          fd.st = CAP_SHORT;
        end else begin
          fd.cap_word = fq.sh;
          fd.cap_len = len_of(fq.cnt);
          fd.cap_tgl = ~fq.cap_tgl;
          fd.st = CAP_IDLE;
        end
      end
      CAP_SHORT: begin
        fd.sh = {fq.sh[WORD_W-2:0], i_decoder_serial_in};
        fd.cnt = fq.cnt + 4'h1;
        if (fd.cnt == LEN_32K) begin
          fd.cap_word = fd.sh;
          fd.cap_len = LEN_32K;
          fd.cap_tgl = ~fq.cap_tgl;
          fd.st = CAP_IDLE;
        end
      end
      default: fd.st = CAP_IDLE;
    endcase
    // long frame detect and half-period cut of the last bit
    if (!rq.act) begin
      fd.long_cnt = 2'h0;
      fd.cut = 1'b0;
    end else begin
      if (i_decoder_output_request && !is_long) begin
        fd.long_cnt = fq.long_cnt + 2'h1;
      end
      if (last_bit && !i_decoder_output_request) begin
        fd.cut = 1'b1;
      end
    end
  end

  always_ff @(negedge i_decoder_bit_clock or posedge i_reset) begin
    if (i_reset) begin
      fq <= '0;
    end else begin
      fq <= fd;
    end
  end

  //----------------------------------------------------------------
  // core clock: three-frame pipeline and hand-off to the link
  //----------------------------------------------------------------
  // each captured word advances pending -> decode -> fifo
  always_comb begin
    cd = cq;
    cd.cap_sync = {cq.cap_sync[0], fq.cap_tgl};
    cd.ack_sync = {cq.ack_sync[0], rq.ack_tgl};
    cd.drop = 1'b0;
    wr_v = 1'b0;
    rd_r = 1'b0;
    // capture fields read raw: they hold still for a frame after the toggle
    if (cq.cap_sync[1] != cq.cap_seen) begin
      cd.cap_seen = cq.cap_sync[1];
      if (!cq.dec_v || fifo_bus.wr_ready) begin
        wr_v = cq.dec_v;
        cd.dec_v = cq.pend_v;
        cd.dec = justify(cq.pend);
        cd.pend_v = 1'b1;
        cd.pend = {fq.cap_len, fq.cap_word};
      end else begin
        cd.drop = 1'b1;
      end
    end
    // next word to the link once the last one is acknowledged
    if ((cq.ack_sync[1] == cq.xfer_tgl) && fifo_bus.rd_valid) begin
      rd_r = 1'b1;
      cd.xfer = fifo_bus.rd_data;
      cd.xfer_tgl = ~cq.xfer_tgl;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cq <= '0;
    end else begin
      cq <= cd;
    end
  end

  // fifo hookup
  // pushes only on a capture event; pops only toward the link transfer
  assign fifo_bus.wr_valid = wr_v;
  assign fifo_bus.wr_data = cq.dec;
  assign fifo_bus.rd_ready = rd_r;

  pdo_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH_P)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .io(fifo_bus.fifo)
  );

  //----------------------------------------------------------------
  // link rising edge: word hold and output shifter
  //----------------------------------------------------------------
  // take the offered word, then shift it out per request
  always_comb begin
    rd = rq;
    rd.req_sync = {rq.req_sync[0], cq.xfer_tgl};
    rd.req_prev = i_decoder_output_request;
    // one-word mailbox; the ack toggle frees the core side to refill
    if (!rq.hold_v && (rq.req_sync[1] != rq.ack_tgl)) begin
      rd.hold = cq.xfer;
      rd.hold_v = 1'b1;
      rd.ack_tgl = rq.req_sync[1];
    end
    unique case (rq.st)
      OUT_IDLE: begin
        // one word per request edge
        if (i_decoder_output_request && !rq.req_prev && rq.hold_v) begin
          rd.hold_v = 1'b0;
          rd.word = rq.hold[WORD_W-1:0];
          rd.sh = rq.hold[WORD_W-1:0];
          rd.len = rq.hold[ENTRY_W-1:WORD_W];
          rd.idx = LEN_RST;
          rd.act = 1'b1;
          rd.dout = rq.hold[WORD_W-1];
          rd.st = OUT_SEND;
        end
      end
      OUT_SEND: begin
        if ((rq.idx + 4'h1) < total) begin
          rd.idx = rq.idx + 4'h1;
          rd.sh = {rq.sh[WORD_W-2:0], 1'b0};
          rd.dout = rq.sh[WORD_W-2];
        end else if (is_long && i_decoder_output_request) begin
          rd.idx = LEN_RST;
          rd.sh = rq.word;
          rd.dout = rq.word[WORD_W-1];
        end else begin
          rd.act = 1'b0;
          rd.dout = 1'b0;
          rd.st = OUT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_decoder_bit_clock or posedge i_reset) begin
    if (i_reset) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end

  //----------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------
  // enable is two edge flops: a half-period lsb must release on a fall
  // while every other change happens on a rise
  assign o_decoder_serial_out = rq.dout;
  assign o_decoder_serial_out_oe_n = !rq.act || fq.cut;
  assign o_overrun = cq.drop;

endmodule

`default_nettype wire

// [pdo_serial_out_assertions.sv]
// pin-level checks for the decoder serial output port
`timescale 1ns/10ps
`default_nettype none
module pdo_serial_out_assertions #(
  parameter int DEPTH_P = 16
) (
  input wire logic i_clk, // core clock
  input wire logic i_reset, // async reset, high
  input wire logic i_decoder_bit_clock, // link clock
  input wire logic i_decoder_input_strobe, // input strobe
  input wire logic i_decoder_serial_in, // serial in
  input wire logic i_decoder_output_request, // output request
  input wire logic o_decoder_serial_out, // serial out
  input wire logic o_decoder_serial_out_oe_n, // low while driving
  input wire logic o_overrun // drop pulse
);
  logic neg_q; // data level at last falling edge
  logic [3:0] run_q; // driven rises with request high
  // ------
  // helpers
  // ------
  // data must not move between a falling and the next rising edge
  always_ff @(negedge i_decoder_bit_clock or posedge i_reset) begin
    if (i_reset) neg_q <= 1'b0;
    else neg_q <= o_decoder_serial_out;
  end
  // length of the current held-request run, saturating
  always_ff @(posedge i_decoder_bit_clock or posedge i_reset) begin
    if (i_reset) run_q <= 4'h0;
    else if (o_decoder_serial_out_oe_n || !i_decoder_output_request) run_q <= 4'h0;
    else if (run_q != 4'hf) run_q <= run_q + 4'h1;
  end
  // ------
  // properties
  // ------
  sequence s_long_start;
    $fell(o_decoder_serial_out_oe_n) && i_decoder_output_request ##1 i_decoder_output_request;
  endsequence
  property p_idle_zero;
    @(posedge i_decoder_bit_clock) disable iff (i_reset)
      $past(o_decoder_serial_out_oe_n) && o_decoder_serial_out_oe_n |-> !o_decoder_serial_out;
  endproperty
  property p_start_on_rise;
    @(posedge i_decoder_bit_clock) disable iff (i_reset) $fell(o_decoder_serial_out_oe_n)
      |-> $past(i_decoder_output_request) && !$past(i_decoder_output_request, 2);
  endproperty
  property p_no_req;
    @(posedge i_decoder_bit_clock) disable iff (i_reset)
      o_decoder_serial_out_oe_n && !i_decoder_output_request |=> o_decoder_serial_out_oe_n;
  endproperty
  property p_launch;
    @(posedge i_decoder_bit_clock) disable iff (i_reset) o_decoder_serial_out == neg_q;
  endproperty
  property p_long_min;
    @(posedge i_decoder_bit_clock) disable iff (i_reset)
      s_long_start |-> !o_decoder_serial_out_oe_n [*6];
  endproperty
  property p_lsb_stretch;
    @(posedge i_decoder_bit_clock) disable iff (i_reset)
      s_long_start ##1 i_decoder_output_request [*5] |=> !o_decoder_serial_out_oe_n;
  endproperty
  property p_recirc;
    @(posedge i_decoder_bit_clock) disable iff (i_reset)
      run_q >= 4'h8 && !o_decoder_serial_out_oe_n && i_decoder_output_request
      |-> o_decoder_serial_out == $past(o_decoder_serial_out, 8);
  endproperty
  property p_drop_pulse;
    @(posedge i_clk) disable iff (i_reset) o_overrun |=> !o_overrun;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data while idle");
  a_start_on_rise: assert property (p_start_on_rise) else $error("start without rise");
  a_no_req: assert property (p_no_req) else $error("drive without request");
  a_launch: assert property (p_launch) else $error("data moved off rise");
  a_long_min: assert property (p_long_min) else $error("long word short");
  a_lsb_stretch: assert property (p_lsb_stretch) else $error("lsb cut");
  a_recirc: assert property (p_recirc) else $error("no repeat");
  a_drop_pulse: assert property (p_drop_pulse) else $error("drop pulse long");
endmodule

bind pdo_serial_out pdo_serial_out_assertions #(.DEPTH_P(DEPTH_P)) u_pdo_serial_out_assertions (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_decoder_bit_clock(i_decoder_bit_clock),
  .i_decoder_input_strobe(i_decoder_input_strobe),
  .i_decoder_serial_in(i_decoder_serial_in),
  .i_decoder_output_request(i_decoder_output_request),
  .o_decoder_serial_out(o_decoder_serial_out),
  .o_decoder_serial_out_oe_n(o_decoder_serial_out_oe_n),
  .o_overrun(o_overrun)
);
`default_nettype wire

// [pdo_link_model.sv]
// far side of the port: bit clock, input frames, output requests
`timescale 1ns/10ps
`default_nettype none
module pdo_link_model (
  output logic o_bclk, // bit clock, still low between frames
  output logic o_strobe, // input strobe
  output logic o_din, // serial data to the port
  output logic o_req, // output request
  input wire logic i_dout, // serial data from the port
  input wire logic i_oe_n // low while the port drives
);
  logic [15:0] cap; // first bits read this frame
  int n_cap; // all bits read this frame
  int n_low; // low phases with the port still driving
  initial begin
    o_bclk = 1'b0;
    o_strobe = 1'b0;
    o_din = 1'b0;
    o_req = 1'b0;
    cap = 16'h0000;
    n_cap = 0;
    n_low = 0;
  end
  // one bit period: input set in high phase, request in low phase
  task automatic tick(input logic s, input logic v, input logic d, input logic r);
    o_bclk = 1'b1;
    #16;
    o_strobe = s;
    o_din = v ? d : ~o_din; // released line toggles
    #15;
    if (i_oe_n === 1'b0) begin
      if (n_cap < 16) cap = {cap[14:0], i_dout};
      n_cap++;
    end
    #1;
    o_bclk = 1'b0;
    #16;
    if (i_oe_n === 1'b0) n_low++;
    o_req = r;
    #16;
  endtask
  // input word of ne strobe edges, then a read held for rq rises
  task automatic frame(input int ne, input logic [7:0] w, input int rq);
    cap = 16'h0000;
    n_cap = 0;
    n_low = 0;
    for (int i = 0; i < ne; i++) tick(1'b1, ne > 1, w[7-i], 1'b0);
    for (int i = 0; i < ((ne == 1) ? 4 : 0); i++) tick(1'b0, 1'b1, w[7-i], 1'b0);
    repeat (6) tick(1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < rq + 12; i++) tick(1'b0, 1'b0, 1'b0, i < rq);
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the decoder serial output port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench
  import pdo_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b0; // raised by do_reset so the first reset is an edge
  wire bclk, strobe, din, req, dout, oe_n, ovr;
  int mismatches = 0;
  int n_compared = 0;
  int n_ovr = 0;
  // 25 MHz core clock and drop counter
  always #20 clk = ~clk;
  always @(posedge clk) if (ovr === 1'b1) n_ovr++;
  pdo_serial_out u_pdo_serial_out (.i_clk(clk), .i_reset(rst), .i_decoder_bit_clock(bclk),
    .i_decoder_input_strobe(strobe), .i_decoder_serial_in(din),
    .i_decoder_output_request(req), .o_decoder_serial_out(dout),
    .o_decoder_serial_out_oe_n(oe_n), .o_overrun(ovr));
  pdo_link_model u_pdo_link_model (.o_bclk(bclk), .o_strobe(strobe), .o_din(din),
    .o_req(req), .i_dout(dout), .i_oe_n(oe_n));
  // expected word length for a count of strobe edges
  function automatic int len_of(input int ne);
    return ne == 2 ? LEN_16K : ne == 3 ? LEN_24K : (ne == 4 || ne == 1) ? LEN_32K : LEN_64K;
  endfunction
  task automatic do_reset();
    @(negedge clk) rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    n_ovr = 0;
  endtask
  task automatic run(input int ne, input logic [7:0] w, input int rq);
    @(negedge clk);
    u_pdo_link_model.frame(ne, w, rq);
  endtask
  // every rate, then two frames of latency before each read
  task automatic test_rates();
    int ne[7] = '{8, 4, 3, 2, 1, 8, 8};
    int n;
    do_reset();
    for (int k = 0; k < 7; k++) begin
      run(ne[k], 8'(8'h5a + 37 * k), 1);
      if (k < 2) begin
        `CHK(u_pdo_link_model.n_cap, 0)
      end else begin
        n = len_of(ne[k-2]);
        `CHK(u_pdo_link_model.n_cap, n)
        `CHK(u_pdo_link_model.cap[7:0], 8'(8'(8'h5a + 37 * (k-2)) >> (8 - n)))
        `CHK(u_pdo_link_model.n_low, n - 1)
      end
    end
    $display("test_rates done");
  endtask
  // long reads: padded eight bits, then held request repeats them
  task automatic test_long();
    do_reset();
    run(2, 8'hc3, 1);
    run(3, 8'ha5, 1);
    run(8, 8'h3c, 2);
    `CHK(u_pdo_link_model.n_cap, 8)
    `CHK(u_pdo_link_model.cap[7:0], 8'hc0)
    `CHK(u_pdo_link_model.n_low, 7)
    run(8, 8'h69, 16);
    `CHK(u_pdo_link_model.n_cap, 16)
    `CHK(u_pdo_link_model.n_low, 16)
    `CHK(u_pdo_link_model.cap, 16'ha0a0)
    $display("test_long done");
  endtask
  // fill with no reads until words drop, then drain to empty
  task automatic test_fill();
    do_reset();
    for (int k = 0; k < 22; k++) begin
      run(8, 8'(37 * k + 1), 0);
      if (k == 16) `CHK(n_ovr, 0)
    end
    `CHK(n_ovr, 1)
    // fifo, its output register, link transfer and hold keep 19 words
    for (int k = 0; k < 20; k++) begin
      run(0, 8'h00, 1);
      `CHK(u_pdo_link_model.n_cap, k < 19 ? 8 : 0)
      if (k < 19) `CHK(u_pdo_link_model.cap[7:0], 8'(37 * k + 1))
    end
    $display("test_fill done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    test_rates();
    test_long();
    test_fill();
    report_and_stop();
  end
  // some 53 frames of about 1.5 us each; five times that is a hang
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
